/* File: src/cmp_panel.sv */
// console maintenance panel: keys, lights, mode selector, alter and display
`timescale 1ns/1ps
`default_nettype none
module cmp_panel
    import cmp_pkg::*;
#(
    parameter int POWER_ON_CYC = CMP_POWER_ON_CYC
) (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic LOAD_KEY,
    input wire logic START_KEY,
    input wire logic STOP_KEY,
    input wire logic CE_START_KEY,
    input wire logic [5:0] MODE_SEL,
    input wire logic STOR_SEL_CS,
    input wire logic [15:0] DATA_SW,
    input wire logic KEYBD_READY_IN,
    input wire logic LOAD_BYTE_OK,
    input wire logic PROGRAM_LOAD_DONE,
    input wire logic ADDR_COMPARE_STOP,
    input wire logic UNRECOVERABLE_ERR,
    input wire logic INSN_END,
    input wire logic MICRO_END,
    input wire logic [2:0] CUR_LEVEL,
    input wire logic [15:0] LOCAL_STORAGE_REG_DATA,
    input wire logic [17:0] STOR_RDATA,
    input wire logic STOR_ACK,
    output logic [7:0] LOCAL_STORAGE_REG_SEL,
    output cmp_stor_req_t STOR_REQ,
    output logic [15:0] MICROPROGRAM_ADDRESS_REG,
    output logic [2:0] MAR_LEVEL,
    output logic MAR_LOAD,
    output logic MICROPROGRAM_INITIAL_LOAD,
    output logic PU_CLOCK_RUN,
    output logic MICRO_STEP,
    output logic SYSTEM_INSTRUCTION_STEP_MODE_GO,
    output logic LOAD_LIGHT,
    output logic START_LIGHT,
    output logic STOP_LIGHT,
    output logic KEYBOARD_READY_LIGHT,
    output logic PROCESSOR_CHECK_LIGHT,
    output logic [17:0] DISPLAY_LIGHTS
);
    // ==========================================================
    // input synchronisers
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] raw_in, s1_q, s2_q, s3_q;
    assign raw_in = {LOAD_KEY, START_KEY, STOP_KEY, CE_START_KEY, STOR_SEL_CS,
                     KEYBD_READY_IN, 1'b0};
    logic [5:0] mode_s1_q, mode_s2_q;
    logic [15:0] sw_s1_q, sw_s2_q;
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            mode_s1_q <= 6'h01;
            mode_s2_q <= 6'h01;
            sw_s1_q <= 16'h0000;
            sw_s2_q <= 16'h0000;
        end else begin
            s1_q <= raw_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            mode_s1_q <= MODE_SEL;
            mode_s2_q <= mode_s1_q;
            sw_s1_q <= DATA_SW;
            sw_s2_q <= sw_s1_q;
        end
    end
    logic load_p, start_p, stop_lvl, ce_p, sel_cs, kb_rdy;
    assign load_p = s2_q[6] & ~s3_q[6];
    assign start_p = s2_q[5] & ~s3_q[5];
    assign stop_lvl = s2_q[4];
    assign ce_p = s2_q[3] & ~s3_q[3]; // see RULE_20
    assign sel_cs = s2_q[2]; // see RULE_14
    assign kb_rdy = s2_q[1];
    cmp_mode_t mode;
    assign mode = cmp_mode_t'(mode_s2_q);
    logic in_run, in_sys;
    assign in_run = (mode == CMP_MODE_RUN);
    assign in_sys = (mode == CMP_MODE_SYS_STEP);
    logic [5:0] mode_prev_q;
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            mode_prev_q <= 6'h01;
        end else begin
            mode_prev_q <= mode_s2_q;
        end
    end
    logic enter_dply;
    assign enter_dply = (mode == CMP_MODE_DISPLAY_STORAGE_MODE) && (mode_prev_q != mode_s2_q);

    // ==========================================================
    // power-on timer
    logic [31:0] pwr_cnt_q;
    logic pwr_done_q;
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            pwr_cnt_q <= 32'h00000000;
            pwr_done_q <= 1'b0;
        end else if (!pwr_done_q) begin
            pwr_cnt_q <= pwr_cnt_q + 32'h00000001;
            if (pwr_cnt_q >= 32'(POWER_ON_CYC - 1)) begin
                pwr_done_q <= 1'b1; // see RULE_05
            end
        end
    end
    logic pwr_done_p;
    assign pwr_done_p = !pwr_done_q && (pwr_cnt_q >= 32'(POWER_ON_CYC - 1));

    // ==========================================================
    // load light and microprogram load
    logic [12:0] load_cnt_q;
    logic load_light_q;
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            load_light_q <= 1'b0;
            load_cnt_q <= 13'h0000;
        end else if (load_p) begin
            load_light_q <= 1'b1; // see RULE_01
            load_cnt_q <= 13'h0000;
        end else if (load_light_q && LOAD_BYTE_OK) begin
            load_cnt_q <= load_cnt_q + 13'h0001;
            if (load_cnt_q == CMP_LOAD_CNT_W_MAX - 13'h0001) begin
                load_light_q <= 1'b0; // see RULE_01
            end
        end
    end
    assign MICROPROGRAM_INITIAL_LOAD = load_light_q;

    // ==========================================================
    // processor check
    logic chk_q;
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            chk_q <= 1'b0;
        end else if (load_p) begin
            chk_q <= 1'b0; // see RULE_07
        end else if (UNRECOVERABLE_ERR) begin
            chk_q <= 1'b1; // see RULE_07
        end
    end

    // ==========================================================
    // start and stop lights
    logic start_q, stop_q, stop_pend_q;
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            stop_pend_q <= 1'b0;
        end else if (INSN_END || !start_q) begin
            stop_pend_q <= 1'b0;
        end else if (stop_lvl) begin
            stop_pend_q <= 1'b1;
        end
    end
    logic halt_now;
    assign halt_now = start_q && INSN_END && (stop_pend_q || stop_lvl); // see RULE_04
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            start_q <= 1'b0;
        end else if (halt_now || in_sys || ADDR_COMPARE_STOP || chk_q) begin
            start_q <= 1'b0; // see RULE_02
        end else if (PROGRAM_LOAD_DONE) begin
            start_q <= 1'b1; // see RULE_02
        end else if (stop_q && start_p) begin
            start_q <= 1'b1; // see RULE_03
        end
    end
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            stop_q <= 1'b0;
        end else if (pwr_done_p || halt_now || in_sys || ADDR_COMPARE_STOP) begin
            stop_q <= 1'b1; // see RULE_04
        end else if (load_p) begin
            stop_q <= 1'b0; // see RULE_06
        end else if (stop_q && start_p && !chk_q) begin
            stop_q <= 1'b0; // see RULE_03
        end
    end

    // ==========================================================
    // processing unit clock gating
    logic run_q;
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            run_q <= 1'b1;
        end else if (!in_run && MICRO_END) begin
            run_q <= 1'b0; // see RULE_09
        end else if (in_run && ce_p) begin
            run_q <= 1'b1; // see RULE_10
        end
    end
    // clock keeps running until the micro-op in progress ends, except on a processor check, which stops it at once
    assign PU_CLOCK_RUN = run_q && !chk_q; // see RULE_09
    assign MICRO_STEP = !run_q && (mode == CMP_MODE_STEP_LSR) && ce_p; // see RULE_11
    assign SYSTEM_INSTRUCTION_STEP_MODE_GO = in_sys && ce_p;

    // ==========================================================
    // alter and display sequencer
    cmp_state_t st_q;
    logic [15:0] mar_q;
    logic [17:0] sdr_q;
    logic [17:0] disp_q;
    logic mar_load_q;
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            st_q <= CMP_ST_IDLE;
        end else begin
            unique case (st_q)
                CMP_ST_IDLE: begin
                    if (ce_p && !run_q && mode == CMP_MODE_ALTER_STOR) begin
                        st_q <= CMP_ST_WRITE;
                    end else if (ce_p && !run_q && mode == CMP_MODE_DISPLAY_STORAGE_MODE) begin
                        st_q <= CMP_ST_READ;
                    end
                end
                CMP_ST_WRITE: begin
                    if (STOR_ACK) begin
                        st_q <= CMP_ST_IDLE;
                    end
                end
                CMP_ST_READ: begin
                    if (STOR_ACK) begin
                        st_q <= CMP_ST_SHOW;
                    end
                end
                CMP_ST_SHOW: begin
                    st_q <= CMP_ST_IDLE;
                end
            endcase
        end
    end
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            mar_q <= CMP_ADDR_RST;
            mar_load_q <= 1'b0;
        end else begin
            mar_load_q <= 1'b0;
            if (ce_p && !run_q && mode == CMP_MODE_ALTER_ADDR) begin
                mar_q <= sw_s2_q; // see RULE_12
                mar_load_q <= 1'b1;
            end else if ((st_q == CMP_ST_WRITE || st_q == CMP_ST_READ) && STOR_ACK) begin
                mar_q <= mar_q + 16'h0001; // see RULE_16
                mar_load_q <= 1'b1;
            end
        end
    end
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            sdr_q <= 18'h00000;
        end else if (st_q == CMP_ST_READ && STOR_ACK) begin
            sdr_q <= STOR_RDATA; // see RULE_18
        end
    end
    logic sel_cs_q;
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            sel_cs_q <= 1'b0;
        end else if (st_q == CMP_ST_IDLE) begin
            sel_cs_q <= sel_cs;
        end
    end
    always_comb begin
        STOR_REQ.req = (st_q == CMP_ST_WRITE) || (st_q == CMP_ST_READ);
        STOR_REQ.we = (st_q == CMP_ST_WRITE);
        STOR_REQ.sel_cs = sel_cs_q; // see RULE_14
        STOR_REQ.addr = mar_q;
        STOR_REQ.wdata = sel_cs_q ? {2'b00, sw_s2_q} : {10'h000, sw_s2_q[7:0]}; // see RULE_15
    end

    // ==========================================================
    // display lights
    logic [17:0] sdr_view;
    assign sdr_view = sel_cs_q ? sdr_q : {CMP_HI_FORCED, sdr_q[8:0]}; // see RULE_19
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            disp_q <= 18'h00000;
        end else begin
            unique case (mode)
                CMP_MODE_STEP_LSR: disp_q <= {2'b00, LOCAL_STORAGE_REG_DATA}; // see RULE_11
                CMP_MODE_ALTER_ADDR: disp_q <= {2'b00, sw_s2_q}; // see RULE_12
                CMP_MODE_ALTER_STOR: disp_q <= {2'b00, sw_s2_q}; // see RULE_15
                CMP_MODE_DISPLAY_STORAGE_MODE: disp_q <= sdr_view; // see RULE_17
                default: disp_q <= {2'b00, mar_q};
            endcase
        end
    end

    assign LOCAL_STORAGE_REG_SEL = sw_s2_q[7:0]; // see RULE_11
    assign MICROPROGRAM_ADDRESS_REG = mar_q;
    assign MAR_LEVEL = CUR_LEVEL;
    assign MAR_LOAD = mar_load_q;
    assign LOAD_LIGHT = load_light_q;
    assign START_LIGHT = start_q;
    assign STOP_LIGHT = stop_q;
    assign KEYBOARD_READY_LIGHT = kb_rdy; // see RULE_08
    assign PROCESSOR_CHECK_LIGHT = chk_q;
    assign DISPLAY_LIGHTS = disp_q;

    // ==========================================================
    // checks
    a_alter_incr: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (st_q == CMP_ST_WRITE && STOR_ACK) |=> mar_q == $past(mar_q) + 16'h0001) // see RULE_16
        else $error("address not incremented after alter");
    a_disp_incr: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (st_q == CMP_ST_READ && STOR_ACK) |=> (mar_q == $past(mar_q) + 16'h0001)
        && (sdr_q == $past(STOR_RDATA))) // see RULE_18
        else $error("display cycle wrong");
    a_alter_addr: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (ce_p && !run_q && mode == CMP_MODE_ALTER_ADDR) |=> mar_q == $past(sw_s2_q)) // see RULE_12
        else $error("address not loaded from switches");
    a_load_light: assert property (@(posedge CLK_SYS) disable iff (RESET)
        load_p |=> LOAD_LIGHT) // see RULE_01
        else $error("load light not lit");
    a_stop_load: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (load_p && !pwr_done_p && !halt_now && !in_sys && !ADDR_COMPARE_STOP)
        |=> !STOP_LIGHT) // see RULE_06
        else $error("stop light not cleared by load");
    a_check_hold: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (chk_q && !load_p) |=> chk_q && !PU_CLOCK_RUN) // see RULE_07
        else $error("check light dropped without load");
    a_clock_stop: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (!in_run && MICRO_END) |=> !run_q) // see RULE_09
        else $error("clock not stopped after micro op");
    a_main_view: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (mode == CMP_MODE_DISPLAY_STORAGE_MODE && !sel_cs_q) |=> DISPLAY_LIGHTS[17:9] == CMP_HI_FORCED) // see RULE_19
        else $error("high display byte not forced");
    a_ce_one: assert property (@(posedge CLK_SYS) disable iff (RESET)
        ce_p |=> !ce_p) // see RULE_20
        else $error("console start pulse too long");
    a_start_resume: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (stop_q && start_p && !chk_q && !halt_now && !in_sys && !ADDR_COMPARE_STOP
        && !pwr_done_p) |=> START_LIGHT && !STOP_LIGHT) // see RULE_03
        else $error("start press did not resume");
endmodule
`default_nettype wire

/* File: src/cmp_pkg.sv */
// package for the console maintenance panel: constants and carrier types
// Function
// (RULE_01) load light on until first 4096 bytes loaded
// (RULE_02) start light set at load, cleared by stops
// (RULE_03) start press while stopped resumes, swaps lights
// (RULE_04) stop press halts at instruction end
// (RULE_05) power-on reset then stop light after 35s
// (RULE_06) load key press turns stop light off
// (RULE_07) unrecoverable error lights check, only load restarts
// (RULE_08) keyboard ready light follows keyboard ready
// (RULE_09) leaving run stops clock after current micro-op
// (RULE_10) start at run resumes at address register
// (RULE_11) step mode runs one micro-op, shows register
// (RULE_12) alter address loads 16 switch bits
// (RULE_13) operator restores original address before returning
// (RULE_14) storage select picks main or control storage
// (RULE_15) alter writes switches 3-4 or 1-4
// (RULE_16) each alter cycle increments address by one
// (RULE_17) display mode shows storage data register at once
// (RULE_18) display cycle reads, shows, increments address
// (RULE_19) control word 18 bits, main byte high forced
// (RULE_20) console start synchronised, one cycle per press
package cmp_pkg;
    localparam int CMP_LOAD_BYTES = 4096;
    localparam int CMP_CLK_HZ = 20000000;
    localparam int CMP_POWER_ON_S = 35;
    localparam int CMP_POWER_ON_CYC = CMP_POWER_ON_S * CMP_CLK_HZ;
    localparam int CMP_ADDR_W = 16;
    localparam int CMP_CS_W = 18;
    localparam int CMP_MS_W = 9;
    localparam int CMP_LSR_AW = 8;
    localparam int CMP_LVL_W = 3;
    localparam logic [15:0] CMP_ADDR_RST = 16'h0000;
    localparam logic [8:0] CMP_HI_FORCED = 9'h1FF;
    localparam logic [12:0] CMP_LOAD_CNT_W_MAX = 13'h1000;

    // mode selector positions, one-hot from the switch
    typedef enum logic [5:0] {
        CMP_MODE_RUN = 6'h01,
        CMP_MODE_STEP_LSR = 6'h02,
        CMP_MODE_ALTER_ADDR = 6'h04,
        CMP_MODE_ALTER_STOR = 6'h08,
        CMP_MODE_DISPLAY_STORAGE_MODE = 6'h10,
        CMP_MODE_SYS_STEP = 6'h20
    } cmp_mode_t;

    typedef enum logic [3:0] {
        CMP_ST_IDLE = 4'h1,
        CMP_ST_WRITE = 4'h2,
        CMP_ST_READ = 4'h4,
        CMP_ST_SHOW = 4'h8
    } cmp_state_t;

    // storage access request towards the processing unit
    typedef struct packed {
        logic req;
        logic we;
        logic sel_cs;
        logic [15:0] addr;
        logic [17:0] wdata;
    } cmp_stor_req_t;
endpackage

/* File: tb/cmp_panel_tb.sv */
// self-checking bench for the console maintenance panel
`timescale 1ns/1ps
`default_nettype none
module cmp_panel_tb;
    import cmp_pkg::*;
    logic clk_sys = 0, reset = 1, ld = 0, st = 0, sp = 0, ce = 0, ssel = 0, kb = 0;
    logic byte_ok = 0, ld_done = 0, cmp_stop = 0, unrec = 0;
    logic [5:0] mode = CMP_MODE_RUN;
    logic [15:0] sw = 16'h0000, base;
    logic [2:0] lvl = 3'h0;
    wire logic ins_end, mic_end, ack, mar_ld, mil, run, mstep, sgo;
    wire logic l_ld, l_st, l_sp, l_kb, l_chk;
    wire logic [15:0] lsr_d, microprogram_address_reg;
    wire logic [17:0] rdat, disp;
    wire logic [7:0] lsr_sel;
    wire logic [2:0] mar_lvl;
    wire cmp_stor_req_t sreq;
    int n_errors = 0, checks_done = 0, seed = 77, n_step = 0, i, s, j, n0;
    logic [17:0] expv [3];
    cmp_panel #(.POWER_ON_CYC(50)) i_cmp_panel (.CLK_SYS(clk_sys), .RESET(reset),
        .LOAD_KEY(ld), .START_KEY(st), .STOP_KEY(sp), .CE_START_KEY(ce), .MODE_SEL(mode),
        .STOR_SEL_CS(ssel), .DATA_SW(sw), .KEYBD_READY_IN(kb), .LOAD_BYTE_OK(byte_ok),
        .PROGRAM_LOAD_DONE(ld_done), .ADDR_COMPARE_STOP(cmp_stop), .UNRECOVERABLE_ERR(unrec),
        .INSN_END(ins_end), .MICRO_END(mic_end), .CUR_LEVEL(lvl),
        .LOCAL_STORAGE_REG_DATA(lsr_d), .STOR_RDATA(rdat), .STOR_ACK(ack),
        .LOCAL_STORAGE_REG_SEL(lsr_sel), .STOR_REQ(sreq), .MICROPROGRAM_ADDRESS_REG(microprogram_address_reg),
        .MAR_LEVEL(mar_lvl), .MAR_LOAD(mar_ld), .MICROPROGRAM_INITIAL_LOAD(mil),
        .PU_CLOCK_RUN(run), .MICRO_STEP(mstep), .SYSTEM_INSTRUCTION_STEP_MODE_GO(sgo), .LOAD_LIGHT(l_ld),
        .START_LIGHT(l_st), .STOP_LIGHT(l_sp), .KEYBOARD_READY_LIGHT(l_kb),
        .PROCESSOR_CHECK_LIGHT(l_chk), .DISPLAY_LIGHTS(disp));
    cmp_pu_model i_cmp_pu_model (.CLK_SYS(clk_sys), .RESET(reset), .STOR_REQ(sreq),
        .PU_CLOCK_RUN(run), .MICRO_STEP(mstep), .LOCAL_STORAGE_REG_SEL(lsr_sel),
        .STOR_RDATA(rdat), .STOR_ACK(ack), .MICRO_END(mic_end), .INSN_END(ins_end),
        .LOCAL_STORAGE_REG_DATA(lsr_d));
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (mstep === 1'b1) n_step++;
    end
    // =====
    // helpers
    task automatic give_verdict();
        if (n_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic chkv(input logic [17:0] got, input logic [17:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chkv({17'h0, got}, {17'h0, exp});
    endtask
    function automatic logic obit(input int k);
        case (k)
            0: return l_ld;
            1: return l_st;
            2: return l_sp;
            3: return l_chk;
            default: return run;
        endcase
    endfunction
    task automatic wait_bit(input int k, input logic v);
        int n;
        for (n = 0; n < 300 && obit(k) !== v; n++) tick(1);
        chk1(obit(k), v);
        if (obit(k) !== v) give_verdict();
    endtask
    // keys held 6 cycles, then released with room for the cycle to finish
    task automatic press(input int k);
        case (k)
            0: ld = 1;
            1: st = 1;
            2: sp = 1;
            default: ce = 1;
        endcase
        tick(6);
        {ld, st, sp, ce} = 4'h0;
        tick(12);
    endtask
    task automatic pulse(input int k);
        case (k)
            0: byte_ok = 1;
            1: ld_done = 1;
            2: cmp_stop = 1;
            default: unrec = 1;
        endcase
        tick(1);
        {byte_ok, ld_done, cmp_stop, unrec} = 4'h0;
        tick(2);
    endtask
    task automatic set_addr(input logic [15:0] a);
        mode = CMP_MODE_ALTER_ADDR;
        sw = a;
        press(3);
    endtask
    // =====
    // main sequence
    initial begin
        tick(6);
        reset = 0;
        chk1(l_ld, 0);
        wait_bit(2, 1);
        for (i = 0; i < 4; i++) begin
            kb = 1'($random(seed));
            tick(4);
            chk1(l_kb, kb);
        end
        press(0);
        chk1(l_ld, 1);
        chk1(mil, 1);
        chk1(l_sp, 0);
        for (i = 0; i < CMP_LOAD_BYTES - 1; i++) pulse(0);
        chk1(l_ld, 1);
        pulse(0);
        chk1(l_ld, 0);
        pulse(1);
        chk1(l_st, 1);
        press(2);
        wait_bit(2, 1);
        chk1(l_st, 0);
        press(1);
        chk1(l_st, 1);
        chk1(l_sp, 0);
        pulse(2);
        chk1(l_st, 0);
        press(1);
        mode = CMP_MODE_STEP_LSR;
        sw = 16'($random(seed));
        wait_bit(4, 0);
        n0 = n_step;
        press(3);
        chkv(n_step - n0, 18'h1);
        chkv({10'h0, lsr_sel}, {10'h0, sw[7:0]});
        chkv({2'h0, disp[15:0]}, {2'h0, ~sw[7:0], sw[7:0]});
        lvl = 3'($random(seed));
        base = 16'($random(seed));
        set_addr(base);
        chkv({2'h0, microprogram_address_reg}, {2'h0, base});
        chkv({15'h0, mar_lvl}, {15'h0, lvl});
        chkv(disp, {2'h0, base});
        for (s = 0; s < 2; s++) begin
            ssel = s[0];
            set_addr(base);
            mode = CMP_MODE_ALTER_STOR;
            for (j = 0; j < 3; j++) begin
                sw = (j == 0) ? 16'hFFFF : 16'($random(seed));
                expv[j] = s ? {2'h0, sw} : {10'h0, sw[7:0]};
                press(3);
                chkv({2'h0, microprogram_address_reg}, {2'h0, base + 16'(j + 1)});
                chkv(disp, {2'h0, sw});
            end
            set_addr(base);
            mode = CMP_MODE_DISPLAY_STORAGE_MODE;
            for (j = 0; j < 3; j++) begin
                press(3);
                chkv(disp, s ? expv[j] : {9'h1FF, expv[j][8:0]});
                chkv({2'h0, microprogram_address_reg}, {2'h0, base + 16'(j + 1)});
            end
        end
        set_addr(base);
        mode = CMP_MODE_DISPLAY_STORAGE_MODE;
        tick(4);
        chkv(disp, expv[2]);
        mode = CMP_MODE_RUN;
        press(3);
        wait_bit(4, 1);
        mode = CMP_MODE_SYS_STEP;
        wait_bit(1, 0);
        wait_bit(2, 1);
        mode = CMP_MODE_RUN;
        pulse(3);
        wait_bit(3, 1);
        press(1);
        chk1(run, 0);
        chk1(l_chk, 1);
        press(0);
        chk1(l_ld, 1);
        wait_bit(3, 0);
        give_verdict();
    end
endmodule
`default_nettype wire

/* File: tb/cmp_pu_model.sv */
// processing unit model: storage, micro-op and instruction pacing
`timescale 1ns/1ps
`default_nettype none
module cmp_pu_model
    import cmp_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire cmp_stor_req_t STOR_REQ,
    input wire logic PU_CLOCK_RUN,
    input wire logic MICRO_STEP,
    input wire logic [7:0] LOCAL_STORAGE_REG_SEL,
    output logic [17:0] STOR_RDATA,
    output logic STOR_ACK,
    output logic MICRO_END,
    output logic INSN_END,
    output logic [15:0] LOCAL_STORAGE_REG_DATA
);
    logic [17:0] cs_mem [256];
    logic [17:0] ms_mem [256];
    logic [1:0] wait_q;
    logic [1:0] ins_q;
    assign LOCAL_STORAGE_REG_DATA = {~LOCAL_STORAGE_REG_SEL, LOCAL_STORAGE_REG_SEL};
    // =====
    // storage: ack after 2 or 4 cycles, read data toggles when idle
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            STOR_ACK <= 1'b0;
            wait_q <= 2'h0;
            STOR_RDATA <= 18'h0;
        end else begin
            STOR_ACK <= 1'b0;
            STOR_RDATA <= ~STOR_RDATA;
            if (STOR_REQ.req && !STOR_ACK) begin
                if (wait_q == {STOR_REQ.addr[0], 1'b1}) begin
                    STOR_ACK <= 1'b1;
                    wait_q <= 2'h0;
                    if (STOR_REQ.we && STOR_REQ.sel_cs) cs_mem[STOR_REQ.addr[7:0]] <= STOR_REQ.wdata;
                    else if (STOR_REQ.we) ms_mem[STOR_REQ.addr[7:0]] <= STOR_REQ.wdata;
                    else if (STOR_REQ.sel_cs) STOR_RDATA <= cs_mem[STOR_REQ.addr[7:0]];
                    else STOR_RDATA <= ms_mem[STOR_REQ.addr[7:0]];
                end else begin
                    wait_q <= wait_q + 2'h1;
                end
            end
        end
    end
    // micro-op every other cycle while running, instruction every fourth micro-op
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            MICRO_END <= 1'b0;
            INSN_END <= 1'b0;
            ins_q <= 2'h0;
        end else begin
            MICRO_END <= (PU_CLOCK_RUN && !MICRO_END) || MICRO_STEP;
            INSN_END <= MICRO_END && PU_CLOCK_RUN && ins_q == 2'h3;
            ins_q <= ins_q + {1'b0, MICRO_END};
        end
    end
endmodule
`default_nettype wire
